// file: design/sys_clk_select.sv
/*
 * System clock source selector: picks fast and slow sources, divides
 * the fast clock, gates clocks for halt modes and switches glitch-free.
 * Assumes oscillator inputs are free-running and asynchronous to clk_i,
 * which runs well above the fastest oscillator; halt_i and wdt_en_i come
 * from logic on clk_i. The generated clocks are sampled replicas, so
 * their edges carry up to one clk_i period of jitter.
 */
// Notes on behaviour
// R1 - Select field picks fast or slow path
// R2 - Low-speed select bit picks slow source
// R3 - High-speed select bit picks fast source
// R4 - Select field also sets clock frequency
// R5 - Always one fast, one slow source chosen
// R6 - Fast RC frequency from configuration option
// R7 - Software matches RC field to option
// R8 - Slow crystal waits start-up after enable
// R9 - Slow crystal gives fixed slow clock
// R10 - Pin bits choose crystal or I/O
// R11 - Oscillators also clock watchdog, time base
// R12 - Sleep stops system clock, any halt stops CPU clock
// R13 - Codes give fast clock down to 1/64
// R14 - All-ones code runs from sub clock
// R15 - Switching makes no glitched clock pulses
`timescale 1ns/1ps
module sys_clk_select #(
    parameter int LXT_STARTUP = clk_sel_pkg::LXT_STARTUP_EDGES
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [3:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire logic fast_crystal_osc_i,
    input wire logic fast_internal_rc_i,
    input wire logic slow_crystal_osc_i,
    input wire logic slow_internal_rc_i,
    input wire logic [1:0] fast_rc_option_i,
    input wire logic halt_i,
    input wire logic wdt_en_i,
    output logic sys_clk_o,
    output logic cpu_clk_o,
    output logic wdt_clk_o,
    output logic time_base_clk_o,
    output logic fast_crystal_en_o,
    output logic fast_rc_en_o,
    output logic slow_crystal_en_o,
    output logic slow_rc_en_o,
    output logic slow_crystal_pins_osc_o,
    output logic slow_crystal_ready_o,
    output logic [1:0] fast_rc_freq_o
);
    localparam int LXT_W = $clog2(LXT_STARTUP + 1);
    localparam logic [LXT_W-1:0] LXT_DONE = LXT_W'(LXT_STARTUP);

    typedef struct packed {
        logic [7:0] system_clock_control;
        logic [7:0] fast_rc_control;
        logic [7:0] lxtc;
        logic ack;
        logic [31:0] dat;
        clk_sel_pkg::sw_state_t sw;
        clk_sel_pkg::clk_sel_t applied;
        logic [clk_sel_pkg::DIV_W-1:0] div_cnt;
        logic [LXT_W-1:0] lxt_cnt;
        logic lxt_ready;
        logic sys_clk;
        logic cpu_gate;
        logic cpu_clk;
        logic wdt_clk;
        logic tb_clk;
        logic hxt_en;
        logic fast_internal_rc_en;
        logic lxt_en;
        logic slow_internal_rc_en;
        logic pins_osc;
        logic [1:0] rc_freq;
    } sel_st_t;

    sel_st_t st;
    sel_st_t next_st;

    osc_sync_if #(.N(clk_sel_pkg::N_SYNC)) sif ();

    // All pin inputs pass the two-flop chain before use
    assign sif.raw = {fast_rc_option_i, slow_internal_rc_i, slow_crystal_osc_i,
                      fast_internal_rc_i, fast_crystal_osc_i};

    osc_sync #(
        .N(clk_sel_pkg::N_SYNC)
    ) u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .sif(sif)
    );

    // Candidate clock level for a given selection
    function automatic logic cand_of(input clk_sel_pkg::clk_sel_t s,
                                     input logic [clk_sel_pkg::DIV_W-1:0] cnt,
                                     input logic [clk_sel_pkg::N_SYNC-1:0] lvl);
        logic fh;
        logic fsub;
        logic r;
        fh = s.high_speed_source_select ? lvl[clk_sel_pkg::CH_HXT] : lvl[clk_sel_pkg::CH_FAST_INTERNAL_RC]; // R3
        fsub = s.low_speed_source_select ? lvl[clk_sel_pkg::CH_LXT] : lvl[clk_sel_pkg::CH_SLOW_INTERNAL_RC]; // R2
        r = 1'b0;
        if (s.off) begin
            r = 1'b0; // R12
        end else if (s.cks == clk_sel_pkg::CKS_SUB) begin
            r = fsub; // R14
        end else if (s.cks == clk_sel_pkg::CKS_FULL) begin
            r = fh; // R1
        end else begin
            // Bit n-1 of the edge counter has period 2^n fast edges
            r = cnt[s.cks - 3'h1]; // R4 R13
        end
        return r;
    endfunction

    logic [2:0] cks_f;
    logic fhs_f;
    logic fss_f;
    logic fhiden;
    logic fsiden;
    logic fsys_on;
    logic fh_on;
    logic fsub_on;
    logic wb_req;
    logic [7:0] wdat;
    logic [1:0] opt;
    clk_sel_pkg::clk_sel_t req;
    logic req_ok;
    logic fh_rise;
    logic cand;

    // Field decode; encodings cover every code, so no path is empty
    always_comb begin
        cks_f = st.system_clock_control[clk_sel_pkg::SCC_CKS_LSB +: 3];
        fhs_f = st.system_clock_control[clk_sel_pkg::SCC_FHS_BIT]; // R5
        fss_f = st.system_clock_control[clk_sel_pkg::SCC_FSS_BIT]; // R5
        fhiden = st.system_clock_control[clk_sel_pkg::SCC_FHIDEN_BIT];
        fsiden = st.system_clock_control[clk_sel_pkg::SCC_FSIDEN_BIT];
        opt = sif.level[clk_sel_pkg::CH_OPT_LSB +: 2];
        wb_req = cyc_i & stb_i & ~st.ack;
        wdat = dat_i[7:0];
    end

    // Halt-mode clock availability: sleep and the idle variants
    always_comb begin
        if (!halt_i) begin
            fsys_on = 1'b1;
        end else if (fhiden && fsiden) begin
            fsys_on = 1'b1;
        end else if (fhiden) begin
            fsys_on = (cks_f != clk_sel_pkg::CKS_SUB);
        end else if (fsiden) begin
            fsys_on = (cks_f == clk_sel_pkg::CKS_SUB);
        end else begin
            fsys_on = 1'b0; // R12
        end
        fh_on = !halt_i || fhiden;
        fsub_on = !halt_i || fsiden;
    end

    // Requested selection; slow crystal only once it has started
    always_comb begin
        req.off = ~fsys_on; // R12
        req.low_speed_source_select = fss_f;
        req.high_speed_source_select = fhs_f;
        req.cks = cks_f;
        req_ok = !(fss_f && cks_f == clk_sel_pkg::CKS_SUB && !fsys_on == 1'b0
                   && !st.lxt_ready); // R8
        fh_rise = st.applied.high_speed_source_select ? sif.rise[clk_sel_pkg::CH_HXT]
                                 : sif.rise[clk_sel_pkg::CH_FAST_INTERNAL_RC];
        cand = cand_of(st.applied, st.div_cnt, sif.level);
    end

    // Whole next state: bus, registers, oscillator control, switching
    always_comb begin
        next_st = st;

        // Classic Wishbone slave: one wait state, ack for one cycle
        next_st.ack = wb_req;
        next_st.dat = '0;
        if (wb_req && we_i && sel_i[0]) begin
            unique case (adr_i)
                clk_sel_pkg::ADDR_SYSTEM_CLOCK_CONTROL: begin
                    next_st.system_clock_control = wdat & clk_sel_pkg::SCC_WRITE_MASK; // R1
                end
                clk_sel_pkg::ADDR_FAST_RC_CONTROL: begin
                    next_st.fast_rc_control = wdat & clk_sel_pkg::FAST_RC_CONTROL_WRITE_MASK;
                end
                clk_sel_pkg::ADDR_SLOW_XTAL_CONTROL: begin
                    next_st.lxtc = wdat & clk_sel_pkg::LXTC_WRITE_MASK; // R10
                end
                default: begin
                    // Unmapped and read-only words ignore writes
                end
            endcase
        end
        if (wb_req && !we_i) begin
            unique case (adr_i)
                clk_sel_pkg::ADDR_SYSTEM_CLOCK_CONTROL: begin
                    next_st.dat[7:0] = st.system_clock_control;
                end
                clk_sel_pkg::ADDR_FAST_RC_CONTROL: begin
                    next_st.dat[7:0] = st.fast_rc_control;
                    // Flags a field that disagrees with the option
                    next_st.dat[clk_sel_pkg::FAST_RC_CONTROL_MISMATCH_BIT] =
                        (st.fast_rc_control[clk_sel_pkg::FAST_RC_CONTROL_FREQ_LSB +: 2] != st.rc_freq); // R7
                    next_st.dat[clk_sel_pkg::FAST_RC_CONTROL_OPTION_LSB +: 2] = st.rc_freq; // R6
                end
                clk_sel_pkg::ADDR_SLOW_XTAL_CONTROL: begin
                    next_st.dat[7:0] = st.lxtc;
                    next_st.dat[clk_sel_pkg::LXTC_READY_BIT] = st.lxt_ready; // R8
                end
                clk_sel_pkg::ADDR_CLOCK_STATUS: begin
                    next_st.dat[5:0] = st.applied;
                    next_st.dat[6] = (st.sw == clk_sel_pkg::SW_HOLD);
                    next_st.dat[7] = halt_i;
                end
                default: begin
                    next_st.dat = '0;
                end
            endcase
        end

        // Fast RC runs at the option frequency, not the software field
        next_st.rc_freq = opt; // R6

        // Fast oscillator enables follow selection and halt mode; slow crystal follows its register
        next_st.hxt_en = fhs_f & fh_on; // R3
        next_st.fast_internal_rc_en = ~fhs_f & fh_on; // R3
        next_st.lxt_en = st.lxtc[clk_sel_pkg::LXTC_EN_BIT]
                         & st.lxtc[clk_sel_pkg::LXTC_PIN_OSC_BIT]; // R8 R10
        // Slow RC stays up for the watchdog even in sleep
        next_st.slow_internal_rc_en = (~fss_f & fsub_on) | wdt_en_i | !halt_i; // R11
        next_st.pins_osc = st.lxtc[clk_sel_pkg::LXTC_PIN_OSC_BIT]; // R10

        // Start-up count in slow crystal edges; restart on disable
        if (!st.lxt_en) begin
            next_st.lxt_cnt = '0;
            next_st.lxt_ready = 1'b0; // R8
        end else if (st.lxt_cnt == LXT_DONE) begin
            next_st.lxt_ready = 1'b1; // R8 R9
        end else if (sif.rise[clk_sel_pkg::CH_LXT]) begin
            next_st.lxt_cnt = st.lxt_cnt + LXT_W'(1); // R8
        end

        // Divider counts edges of the applied fast source
        if (fh_rise) begin
            next_st.div_cnt = st.div_cnt + clk_sel_pkg::DIV_W'(1); // R13
        end

        // Glitch-free switch: leave only at a low level, hold low,
        // and enter the new source only while it is low as well
        unique case (st.sw)
            clk_sel_pkg::SW_RUN: begin
                if (req != st.applied && req_ok && !cand) begin
                    next_st.applied = req; // R1 R15
                    next_st.sw = clk_sel_pkg::SW_HOLD;
                end
            end
            clk_sel_pkg::SW_HOLD: begin
                if (!cand) begin
                    next_st.sw = clk_sel_pkg::SW_RUN; // R15
                end
            end
        endcase
        next_st.sys_clk = (st.sw == clk_sel_pkg::SW_RUN) ? cand : 1'b0; // R15

        // CPU gate moves only while the system clock is low
        if (!next_st.sys_clk) begin
            next_st.cpu_gate = ~halt_i; // R12
        end
        next_st.cpu_clk = next_st.sys_clk & next_st.cpu_gate; // R12 R15

        // Watchdog and time base clocks from the slow sources
        next_st.wdt_clk = sif.level[clk_sel_pkg::CH_SLOW_INTERNAL_RC] & next_st.slow_internal_rc_en; // R11
        next_st.tb_clk = fsub_on & (fss_f ? (sif.level[clk_sel_pkg::CH_LXT] & st.lxt_ready)
                                          : sif.level[clk_sel_pkg::CH_SLOW_INTERNAL_RC]); // R11
    end

    // Single state register, synchronous reset to constants
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st <= '0;
            st.system_clock_control <= clk_sel_pkg::SCC_RESET;
            st.fast_rc_control <= clk_sel_pkg::FAST_RC_CONTROL_RESET;
            st.lxtc <= clk_sel_pkg::LXTC_RESET;
            st.sw <= clk_sel_pkg::SW_RUN;
            st.cpu_gate <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // Every output straight from the state register
    assign dat_o = st.dat;
    assign ack_o = st.ack;
    assign sys_clk_o = st.sys_clk;
    assign cpu_clk_o = st.cpu_clk;
    assign wdt_clk_o = st.wdt_clk;
    assign time_base_clk_o = st.tb_clk;
    assign fast_crystal_en_o = st.hxt_en;
    assign fast_rc_en_o = st.fast_internal_rc_en;
    assign slow_crystal_en_o = st.lxt_en;
    assign slow_rc_en_o = st.slow_internal_rc_en;
    assign slow_crystal_pins_osc_o = st.pins_osc;
    assign slow_crystal_ready_o = st.lxt_ready;
    assign fast_rc_freq_o = st.rc_freq;
endmodule // sys_clk_select

// file: inc/clk_sel_pkg.sv
/*
 * Constants for the system clock source selector: register offsets,
 * field positions, reset values, encodings and the switch state machine.
 * Assumes a 32-bit classic Wishbone register bus with byte addresses.
 */
package clk_sel_pkg;

    // Register byte offsets, one aligned word each
    localparam logic [3:0] ADDR_SYSTEM_CLOCK_CONTROL = 4'h0;
    localparam logic [3:0] ADDR_FAST_RC_CONTROL = 4'h4;
    localparam logic [3:0] ADDR_SLOW_XTAL_CONTROL = 4'h8;
    localparam logic [3:0] ADDR_CLOCK_STATUS = 4'hC;

    // system_clock_control fields
    localparam int SCC_CKS_LSB = 5;
    localparam int SCC_FHS_BIT = 3;
    localparam int SCC_FSS_BIT = 2;
    localparam int SCC_FHIDEN_BIT = 1;
    localparam int SCC_FSIDEN_BIT = 0;
    localparam logic [7:0] SCC_WRITE_MASK = 8'hEF;
    localparam logic [7:0] SCC_RESET = 8'h00;

    // fast_rc_control fields
    localparam int FAST_RC_CONTROL_FREQ_LSB = 0;
    localparam int FAST_RC_CONTROL_MISMATCH_BIT = 2;
    localparam int FAST_RC_CONTROL_OPTION_LSB = 4;
    localparam logic [7:0] FAST_RC_CONTROL_WRITE_MASK = 8'h03;
    localparam logic [7:0] FAST_RC_CONTROL_RESET = 8'h00;

    // slow_xtal_control fields
    localparam int LXTC_EN_BIT = 0;
    localparam int LXTC_PIN_OSC_BIT = 1;
    localparam int LXTC_READY_BIT = 2;
    localparam logic [7:0] LXTC_WRITE_MASK = 8'h03;
    localparam logic [7:0] LXTC_RESET = 8'h00;

    // sysclk_select_field code that picks the sub clock
    localparam logic [2:0] CKS_SUB = 3'h7;
    localparam logic [2:0] CKS_FULL = 3'h0;
    localparam int DIV_W = 6;

    // Slow crystal start-up, in slow crystal rising edges
    localparam int LXT_STARTUP_EDGES = 1024;

    // Synchroniser channel positions
    localparam int CH_HXT = 0;
    localparam int CH_FAST_INTERNAL_RC = 1;
    localparam int CH_LXT = 2;
    localparam int CH_SLOW_INTERNAL_RC = 3;
    localparam int CH_OPT_LSB = 4;
    localparam int N_SYNC = 6;

    typedef enum logic [1:0] {
        SW_RUN = 2'b01,
        SW_HOLD = 2'b10
    } sw_state_t;

    // Applied or requested clock selection
    typedef struct packed {
        logic off;
        logic low_speed_source_select;
        logic high_speed_source_select;
        logic [2:0] cks;
    } clk_sel_t;

endpackage

// file: inc/osc_sync_if.sv
/*
 * Carrier between the clock selector and its input synchroniser.
 * Assumes all members are sampled on the selector's clock.
 */
`timescale 1ns/1ps
interface osc_sync_if #(
    parameter int N = 6
);
    logic [N-1:0] raw;
    logic [N-1:0] level;
    logic [N-1:0] rise;

    modport sync (input raw, output level, output rise);
    modport user (output raw, input level, input rise);
endinterface

// file: design/osc_sync.sv
/*
 * Two-flop synchroniser with a third stage for rising edge detection.
 * Assumes raw inputs are asynchronous to clk_i.
 */
`timescale 1ns/1ps
module osc_sync #(
    parameter int N = 6
) (
    input wire logic clk_i,
    input wire logic rst_i,
    osc_sync_if.sync sif
);
    typedef struct packed {
        logic [N-1:0] s1;
        logic [N-1:0] s2;
        logic [N-1:0] s3;
    } sync_st_t;

    sync_st_t st;
    sync_st_t next_st;

    // Shift chain; second stage feeds level, third only edge detect
    always_comb begin
        next_st.s1 = sif.raw;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // Edge per channel from the settled stages
    for (genvar i = 0; i < N; i++) begin : g_edge
        assign sif.level[i] = st.s2[i];
        assign sif.rise[i] = st.s2[i] & ~st.s3[i];
    end
endmodule // osc_sync

// file: tb/sys_clk_select_sva.sv
/* Checker for the clock selector: bus handshake, clock outputs, halt gating.
   Assumes it is bound to the top module and clk_i is its only clock. */
`timescale 1ns/1ps
module sys_clk_select_sva #(
    parameter int LXT_STARTUP = 4
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    input wire logic [1:0] fast_rc_option_i,
    input wire logic halt_i,
    input wire logic sys_clk_o,
    input wire logic cpu_clk_o,
    input wire logic wdt_clk_o,
    input wire logic slow_rc_en_o,
    input wire logic slow_crystal_en_o,
    input wire logic slow_crystal_pins_osc_o,
    input wire logic slow_crystal_ready_o,
    input wire logic [1:0] fast_rc_freq_o
);
    logic [3:0] up;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Cycles since reset, saturating; gives synchronisers time to flush
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            up <= 4'h0;
        end else if (up != 4'hF) begin
            up <= up + 4'h1;
        end
    end
    sequence s_req;
        cyc_i && stb_i && !ack_o;
    endsequence
    sequence s_ack_pulse;
        ack_o ##1 !ack_o;
    endsequence
    a_ack_single_pulse: assert property (s_req |=> s_ack_pulse)
        else $error("ack not a single pulse after request");
    a_ack_has_cause: assert property (ack_o |-> $past(cyc_i && stb_i))
        else $error("ack without request");
    a_dat_idle_zero: assert property (!ack_o |-> dat_o == 32'h0)
        else $error("read data outside ack");
    a_ready_needs_enable: assert property ($rose(slow_crystal_ready_o) |->
        slow_crystal_en_o && slow_crystal_pins_osc_o)
        else $error("slow crystal ready without enable");
    a_startup_wait: assert property ($rose(slow_crystal_en_o) |-> !slow_crystal_ready_o [*8])
        else $error("slow crystal ready too soon");
    a_rc_option: assert property (up == 4'hF |-> fast_rc_freq_o == fast_rc_option_i)
        else $error("fast rc frequency not from option");
    // Gate closes at the first low system clock seen while halted
    a_cpu_halt_off: assert property ($rose(cpu_clk_o) |->
        !($past(halt_i, 2) && !$past(sys_clk_o)))
        else $error("cpu clock runs while halted");
    a_wdt_gate_off: assert property (!slow_rc_en_o [*2] |-> !wdt_clk_o)
        else $error("watchdog clock without slow rc");
    a_no_runt_pulse: assert property ($changed(sys_clk_o) |=> $stable(sys_clk_o))
        else $error("one cycle pulse on system clock");
endmodule // sys_clk_select_sva

bind sys_clk_select sys_clk_select_sva #(.LXT_STARTUP(LXT_STARTUP)) u_sva (
    .clk_i, .rst_i, .cyc_i, .stb_i, .dat_o, .ack_o, .fast_rc_option_i, .halt_i,
    .sys_clk_o, .cpu_clk_o, .wdt_clk_o, .slow_rc_en_o, .slow_crystal_en_o,
    .slow_crystal_pins_osc_o, .slow_crystal_ready_o, .fast_rc_freq_o
);

// file: tb/sys_clk_select_tb.sv
/* Self-checking bench for the clock selector over classic Wishbone.
   Assumes oscillators made here as exact multiples of clk_i, so periods are exact. */
`timescale 1ns/1ps
module sys_clk_select_tb;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
    logic [3:0] adr_i = 4'h0;
    logic [3:0] sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0;
    logic [31:0] dat_o, rd;
    logic ack_o, sys_clk_o, cpu_clk_o, wdt_clk_o, time_base_clk_o;
    logic fast_crystal_en_o, fast_rc_en_o, slow_crystal_en_o, slow_rc_en_o;
    logic slow_crystal_pins_osc_o, slow_crystal_ready_o;
    logic [1:0] fast_rc_freq_o;
    logic [1:0] fast_rc_option_i = 2'h2;
    logic halt_i = 1'b0, wdt_en_i = 1'b1;
    logic [3:0] osc = 4'h0;
    int half [4] = '{4, 3, 20, 22};
    int cnt [4] = '{0, 0, 0, 0};
    int num_errors = 0, compares = 0, n;

    initial forever #5 clk_i = ~clk_i;

    // Oscillators: fast crystal 8, fast rc 6, slow crystal 40, slow rc 44 cycles
    always @(posedge clk_i) begin
        for (int i = 0; i < 4; i++) begin
            if (cnt[i] == half[i] - 1) begin
                cnt[i] <= 0;
                osc[i] <= ~osc[i];
            end else begin
                cnt[i] <= cnt[i] + 1;
            end
        end
    end

    sys_clk_select #(.LXT_STARTUP(4)) dut (
        .clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
        .fast_crystal_osc_i(osc[0]), .fast_internal_rc_i(osc[1]),
        .slow_crystal_osc_i(osc[2]), .slow_internal_rc_i(osc[3]),
        .fast_rc_option_i, .halt_i, .wdt_en_i, .sys_clk_o, .cpu_clk_o, .wdt_clk_o,
        .time_base_clk_o, .fast_crystal_en_o, .fast_rc_en_o, .slow_crystal_en_o,
        .slow_rc_en_o, .slow_crystal_pins_osc_o, .slow_crystal_ready_o, .fast_rc_freq_o
    );

    task automatic report_and_stop();
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic hang(input string what);
        num_errors++;
        $display("wrong value %s expected response seen none", what);
        report_and_stop();
    endtask

    // One classic cycle; request held until ack is sampled, then a gap cycle
    task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d);
        int i;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= we;
        adr_i <= a;
        sel_i <= 4'hF;
        dat_i <= d;
        i = 0;
        do begin
            @(posedge clk_i);
            i++;
        end while (ack_o !== 1'b1 && i < 50);
        if (i >= 50) hang("bus ack");
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp, input string what);
        wb(1'b0, a, 32'h0);
        check(what, exp, rd);
    endtask

    // Cycles until the system clock reaches a level; bounded
    task automatic wait_lvl(input logic v, output int c);
        c = 0;
        while (sys_clk_o !== v && c < 1000) begin
            @(posedge clk_i);
            c++;
        end
        if (c >= 1000) hang("system clock level");
    endtask

    task automatic period(output int p);
        int a, b;
        wait_lvl(1'b0, a);
        wait_lvl(1'b1, a);
        wait_lvl(1'b0, a);
        wait_lvl(1'b1, b);
        p = a + b;
    endtask

    task automatic count_rise(input int which, output int k);
        logic prev, cur;
        k = 0;
        prev = 1'b1;
        repeat (300) begin
            @(posedge clk_i);
            cur = which == 0 ? sys_clk_o : which == 1 ? cpu_clk_o :
                  which == 2 ? wdt_clk_o : time_base_clk_o;
            if (cur === 1'b1 && prev === 1'b0) k++;
            prev = cur;
        end
    endtask

    // Main sequence
    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (5) @(posedge clk_i);
        rd_chk(4'h0, 32'h0, "scc reset");
        rd_chk(4'h4, 32'h24, "rc ctl reset");
        rd_chk(4'h8, 32'h0, "lxt ctl reset");
        check("pins as io", 32'h0, {31'h0, slow_crystal_pins_osc_o});
        rd_chk(4'h2, 32'h0, "unmapped");
        wb(1'b1, 4'h4, 32'hFF);
        rd_chk(4'h4, 32'h27, "rc ctl mask");
        wb(1'b1, 4'h4, 32'h2);
        rd_chk(4'h4, 32'h22, "rc ctl match");
        check("rc freq out", 32'h2, {30'h0, fast_rc_freq_o});
        wb(1'b1, 4'h0, 32'hFF);
        rd_chk(4'h0, 32'hEF, "scc mask");
        // Every divide code on both fast sources; a pending slow request is overridden
        for (int h = 0; h < 2; h++) begin
            for (int c = 0; c < 7; c++) begin
                wb(1'b1, 4'h0, 32'(c << 5 | h << 3));
                period(n);
                period(n);
                check("sys period", 32'((h ? 8 : 6) << c), 32'(n));
                rd_chk(4'hC, 32'(c | h << 3), "status fast");
            end
            check("fast enables", 32'(h ? 2 : 1), {30'h0, fast_crystal_en_o, fast_rc_en_o});
        end
        wb(1'b1, 4'hC, 32'hFF);
        rd_chk(4'hC, 32'hE, "status read only");
        wb(1'b1, 4'h0, 32'hE0);
        period(n);
        period(n);
        check("slow rc period", 32'd44, 32'(n));
        rd_chk(4'hC, 32'h7, "status slow rc");
        // Slow crystal requested before it has started: switch must wait
        wb(1'b1, 4'h0, 32'hE4);
        repeat (100) @(posedge clk_i);
        rd_chk(4'hC, 32'h7, "switch held");
        wb(1'b1, 4'h8, 32'h3);
        n = 0;
        while (slow_crystal_ready_o !== 1'b1 && n < 2000) begin
            @(posedge clk_i);
            n++;
        end
        if (n >= 2000) hang("slow crystal ready");
        check("pins as osc", 32'h1, {31'h0, slow_crystal_pins_osc_o});
        rd_chk(4'h8, 32'h7, "lxt ctl ready");
        period(n);
        period(n);
        check("slow xtal period", 32'd40, 32'(n));
        rd_chk(4'hC, 32'h17, "status slow xtal");
        count_rise(3, n);
        check("time base runs", 32'h1, 32'(n > 0));
        count_rise(1, n);
        check("cpu runs", 32'h1, 32'(n > 0));
        // Sleep: idle enables clear, fast source selected
        wb(1'b1, 4'h0, 32'h0);
        halt_i <= 1'b1;
        repeat (20) @(posedge clk_i);
        count_rise(0, n);
        check("sys off in sleep", 32'h0, 32'(n));
        count_rise(1, n);
        check("cpu off in sleep", 32'h0, 32'(n));
        count_rise(2, n);
        check("wdt runs", 32'h1, 32'(n > 0));
        wdt_en_i <= 1'b0;
        repeat (20) @(posedge clk_i);
        count_rise(2, n);
        check("wdt stopped", 32'h0, 32'(n));
        halt_i <= 1'b0;
        wdt_en_i <= 1'b1;
        period(n);
        period(n);
        check("sys after wake", 32'd6, 32'(n));
        report_and_stop();
    end
endmodule // sys_clk_select_tb
